// >>> rtl/sag_guard.sv
// apb slave that guards every special register access by cpu mode
//
// Notes on behaviour
// - boot mode may read and write every register group except segmentation.
// - test mode may read and write every register group except segmentation.
// - contactless mode may read but never write firewall configuration.
// - contactless mode may read and write its own dedicated registers.
// - contactless access to hardware registers follows firewall low/high rights.
// - system mode reaches segmentation, system, firewall and hardware groups.
// - user mode hardware access follows rights of the fetching segment.
// - general cpu registers are open in every mode.
// - upper status word is also readable in contactless and user mode.
// - clock select is readable in contactless mode regardless of firewall.
// - segmentation registers are refused outside system mode.
// - both protected pointers never return contents on read.
// - random number register is read only; writes do nothing.
// - both key registers are never readable.
// - a product option locks the first key register completely.
// - shared exchange area is placed and sized only from system mode.
// - segment table sits in ordinary memory, guarded by memory rights only.
// - decisions use only mode, segment rights and firewall words.
// - segment table address resets to zero, disabling all segments.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "sag_params.svh"
module sag_guard #(
  parameter int HW_REGS   = 16,
  parameter bit KEY1_LOCK = 1'b0
) (
  input  wire logic               pclk,           // 20 MHz clock
  input  wire logic               presetn,        // async reset, active low
  input  wire logic               ce,             // clock enable
  input  wire logic               psel,           // apb select
  input  wire logic               penable,        // apb enable
  input  wire logic               pwrite,         // apb direction
  input  wire logic [8:0]         paddr,          // apb byte address
  input  wire logic [31:0]        pwdata,         // apb write data
  output logic      [31:0]        prdata,         // apb read data
  output logic                    pready,         // apb ready
  output logic                    pslverr,        // refused or unmapped
  input  wire sag_pkg::sag_mode_t cpu_mode,       // current cpu mode
  input  wire logic [15:0]        seg_hw_rd,      // fetch segment read rights
  input  wire logic [15:0]        seg_hw_wr,      // fetch segment write rights
  output logic                    grp_sel,        // forwarded group selected
  output logic                    grp_we,         // forwarded write strobe
  output logic      [8:0]         grp_addr,       // forwarded address
  output logic      [31:0]        grp_wdata,      // forwarded write data
  input  wire logic [31:0]        grp_rdata,      // forwarded read data
  output logic      [15:0]        seg_table_base, // segment table address
  output logic      [15:0]        xchg_base,      // exchange area base
  output logic      [15:0]        xchg_size,      // exchange area size
  output logic                    viol_pulse      // one pulse per refusal
);
  import sag_pkg::*;

  if (HW_REGS < 1 || HW_REGS > 16) begin : g_bad_hw_regs
    $error("HW_REGS must be 1..16");
  end

  ////////////////////////////////////////////////////////////////////////
  // state

  sag_ph_t     ph_r;
  sag_mode_t   mode_r;
  logic        ok_r;
  logic        loc_r;
  logic        err_r;
  logic [31:0] prdata_r;
  logic        viol_r;
  logic        vpulse_r;
  logic [8:0]  vaddr_r;
  logic [15:0] seg_r;
  logic [15:0] fwl_r;
  logic [15:0] fwh_r;
  logic [15:0] xb_r;
  logic [15:0] xs_r;

  ////////////////////////////////////////////////////////////////////////
  // decision and decode

  logic ok_now;
  logic loc_now;

  sag_decide #(
    .HW_REGS   (HW_REGS),
    .KEY1_LOCK (KEY1_LOCK)
  ) u_decide (
    .mode      (cpu_mode),
    .addr      (paddr),
    .wr        (pwrite),
    .fw_low    (fwl_r),
    .fw_high   (fwh_r),
    .seg_rd    (seg_hw_rd),
    .seg_wr    (seg_hw_wr),
    .ok        (ok_now),
    .local_sel (loc_now)
  );

  // decision latched at first access cycle so a mode change mid-transfer
  // cannot turn a refusal into a grant
  wire acc_first = ce && psel && penable && (ph_r == PH_SETUP);
  wire done      = ce && psel && penable && (ph_r == PH_ANSWER);
  wire done_wr   = done && ok_r && pwrite;
  wire refused   = done && !ok_r;

  function automatic logic wsel(input logic [8:0] a);
    return done_wr && (paddr == a);
  endfunction

  wire [31:0] gstat_val = {7'h00, vaddr_r, 15'h0000, viol_r};
  wire [31:0] loc_rd    = (paddr == `SAG_SEG_BASE)  ? {16'h0000, seg_r} :
                          (paddr == `SAG_FW_LOW)    ? {16'h0000, fwl_r} :
                          (paddr == `SAG_FW_HIGH)   ? {16'h0000, fwh_r} :
                          (paddr == `SAG_XCHG_BASE) ? {16'h0000, xb_r}  :
                          (paddr == `SAG_XCHG_SIZE) ? {16'h0000, xs_r}  :
                          (paddr == `SAG_GSTAT)     ? gstat_val         : 32'h00000000;
  // refused reads never show protected contents
  wire [31:0] rd_val    = (!ok_now || pwrite) ? 32'h00000000 :
                          (loc_now ? loc_rd : grp_rdata);

  // sticky flag: a new refusal beats a clear in the same cycle
  wire viol_clr = wsel(`SAG_GSTAT) && pwdata[`SAG_VIOL_BIT];
  wire viol_nxt = refused || (viol_r && !viol_clr);

  ////////////////////////////////////////////////////////////////////////
  // apb handshake

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r     <= PH_SETUP;
      mode_r   <= SAG_BOOT;
      ok_r     <= 1'b0;
      loc_r    <= 1'b0;
      err_r    <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (acc_first) begin
      ph_r     <= PH_ANSWER;
      mode_r   <= cpu_mode;
      ok_r     <= ok_now;
      loc_r    <= loc_now;
      err_r    <= !ok_now;
      prdata_r <= rd_val;
    end else if (done) begin
      ph_r     <= PH_SETUP;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // guard registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_r <= `SAG_SEG_RST;
      fwl_r <= `SAG_FW_RST;
      fwh_r <= `SAG_FW_RST;
      xb_r  <= `SAG_XCHG_RST;
      xs_r  <= `SAG_XCHG_RST;
    end else begin
      // writes land only on granted transfers
      if (wsel(`SAG_SEG_BASE))  seg_r <= pwdata[15:0];
      if (wsel(`SAG_FW_LOW))    fwl_r <= pwdata[15:0];
      if (wsel(`SAG_FW_HIGH))   fwh_r <= pwdata[15:0];
      if (wsel(`SAG_XCHG_BASE)) xb_r  <= pwdata[15:0];
      if (wsel(`SAG_XCHG_SIZE)) xs_r  <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      viol_r   <= 1'b0;
      vpulse_r <= 1'b0;
      vaddr_r  <= 9'h000;
    end else if (ce) begin
      viol_r   <= viol_nxt;
      vpulse_r <= refused;
      if (refused) vaddr_r <= paddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // ce low holds the answer back, so a master never completes a frozen transfer
  assign pready         = (ph_r == PH_ANSWER) && ce;
  assign pslverr        = pready && err_r;
  assign prdata         = prdata_r;
  assign grp_sel        = psel && !loc_now;
  // rng and pointer-read refusals reach grp_sel but never the write strobe grp_we
  assign grp_we         = done_wr && !loc_r;
  assign grp_addr       = paddr;
  assign grp_wdata      = pwdata;
  // table contents live in ordinary memory; only its address is held here
  assign seg_table_base = seg_r;
  assign xchg_base      = xb_r;
  assign xchg_size      = xs_r;
  assign viol_pulse     = vpulse_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  wire cmp = psel && penable && pready;

  ready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && psel && penable && !pready) |=> (ph_r == PH_ANSWER) && (pready == ce))
    else $error("ready not raised one cycle into access");

  seg_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && pwrite && paddr == `SAG_SEG_BASE && mode_r != SAG_SYS)
      |-> pslverr ##1 $stable(seg_r))
    else $error("segment base changed outside system mode");

  ptr_hidden_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && !pwrite && (paddr == `SAG_PPTR_ZERO || paddr == `SAG_PPTR_ONE))
      |-> pslverr && prdata == 32'h00000000)
    else $error("protected pointer read returned data");

  rng_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && pwrite && paddr == `SAG_RNG) |-> !grp_we && pslverr)
    else $error("random number register was written");

  key_hidden_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && !pwrite && (paddr == `SAG_KEY_FIRST || paddr == `SAG_KEY_SECOND))
      |-> pslverr && prdata == 32'h00000000)
    else $error("key register was readable");

  fw_ctls_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && cmp && pwrite && mode_r == SAG_CTLS && paddr == `SAG_FW_LOW)
      |=> $stable(fwl_r) && viol_pulse)
    else $error("firewall written in contactless mode");

  viol_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && cmp && pslverr) |=> viol_r && viol_pulse && vaddr_r == $past(paddr))
    else $error("refusal not flagged");

  gen_open_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && paddr[8:6] == 3'h0 && paddr[1:0] == 2'h0) |-> !pslverr)
    else $error("general register refused");

  boot_open_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && mode_r == SAG_BOOT && paddr[8:6] == 3'h4 && paddr[1:0] == 2'h0)
      |-> !pslverr)
    else $error("boot mode refused a dedicated register");

  clk_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && !pwrite && mode_r == SAG_CTLS && paddr == `SAG_CLK_SEL) |-> !pslverr)
    else $error("clock select read refused in contactless mode");

  user_ctls_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && mode_r == SAG_USER && paddr[8:6] == 3'h4) |-> pslverr && !grp_we)
    else $error("user mode reached contactless registers");

  test_open_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && mode_r == SAG_TEST && paddr[8:6] == 3'h4 && paddr[1:0] == 2'h0)
      |-> !pslverr)
    else $error("test mode refused a dedicated register");

  ctls_own_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && mode_r == SAG_CTLS && paddr[8:6] == 3'h4 && paddr[1:0] == 2'h0)
      |-> !pslverr)
    else $error("contactless mode refused its own register");

  fw_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && !pwrite && HW_REGS > 1 && mode_r == SAG_CTLS && paddr == `SAG_RNG)
      |-> pslverr == !fwl_r[1])
    else $error("contactless read ignored firewall rights");

  fw_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && pwrite && mode_r == SAG_CTLS && paddr == `SAG_CLK_SEL)
      |-> pslverr == !fwh_r[0])
    else $error("contactless write ignored firewall rights");

  sys_cfg_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && mode_r == SAG_SYS && (paddr == `SAG_FW_LOW || paddr == `SAG_FW_HIGH ||
      paddr == `SAG_CLK_SEL)) |-> !pslverr)
    else $error("system mode refused a configuration register");

  psw_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && !pwrite && paddr == `SAG_PSW_UPPER &&
      (mode_r == SAG_CTLS || mode_r == SAG_USER)) |-> !pslverr)
    else $error("upper status word read refused");

  xchg_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && pwrite && (paddr == `SAG_XCHG_BASE || paddr == `SAG_XCHG_SIZE) &&
      mode_r != SAG_SYS) |-> pslverr ##1 ($stable(xb_r) && $stable(xs_r)))
    else $error("exchange area moved outside system mode");

  seg_reset_a: assert property (@(posedge pclk)
    !presetn |-> seg_table_base == 16'h0000)
    else $error("segment base not cleared by reset");

  key1_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && KEY1_LOCK && paddr == `SAG_KEY_FIRST)
      |-> pslverr && !grp_we)
    else $error("locked key register was reachable");

  no_fwd_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp && pslverr)
      |-> !grp_we && prdata == 32'h00000000)
    else $error("refused access wrote or returned data");

  viol_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && cmp && !pslverr && pwrite && paddr == `SAG_GSTAT && pwdata[`SAG_VIOL_BIT])
      |=> !viol_r)
    else $error("violation flag not cleared");
endmodule // sag_guard

// >>> rtl/sag_params.svh
// address map, field positions, reset values for the mode access guard
`ifndef SAG_PARAMS_SVH
`define SAG_PARAMS_SVH

`define SAG_AW         9
`define SAG_GRP_LSB    6
`define SAG_IDX_LSB    2
`define SAG_SEG_BASE   9'h040
`define SAG_PSW_UPPER  9'h080
`define SAG_PPTR_ZERO  9'h084
`define SAG_PPTR_ONE   9'h088
`define SAG_XCHG_BASE  9'h090
`define SAG_XCHG_SIZE  9'h094
`define SAG_FW_LOW     9'h0C0
`define SAG_FW_HIGH    9'h0C4
`define SAG_CLK_SEL    9'h140
`define SAG_RNG        9'h144
`define SAG_KEY_FIRST  9'h148
`define SAG_KEY_SECOND 9'h14C
`define SAG_GSTAT      9'h180

`define SAG_VIOL_BIT   0
`define SAG_VADDR_LSB  16

`define SAG_SEG_RST    16'h0000
`define SAG_FW_RST     16'h0000
`define SAG_XCHG_RST   16'h0000

`endif

// >>> rtl/sag_pkg.sv
// types shared by the mode access guard
package sag_pkg;
  typedef enum logic [2:0] {SAG_BOOT, SAG_TEST, SAG_CTLS, SAG_SYS, SAG_USER} sag_mode_t;
  // order follows address bits [8:6]
  typedef enum logic [2:0] {G_GEN, G_SEG, G_SYS, G_FW, G_CTLS, G_HW, G_STAT, G_NONE} sag_grp_t;
  typedef enum logic {PH_SETUP, PH_ANSWER} sag_ph_t;
endpackage

// >>> rtl/sag_decide.sv
// combinational access decision for one register access
`timescale 1ns/10ps
`include "sag_params.svh"
module sag_decide #(
  parameter int  HW_REGS   = 16,
  parameter bit  KEY1_LOCK = 1'b0
) (
  input  wire sag_pkg::sag_mode_t mode,     // current cpu mode
  input  wire logic [8:0]         addr,     // byte address
  input  wire logic               wr,       // 1 write, 0 read
  input  wire logic [15:0]        fw_low,   // read rights per hw register
  input  wire logic [15:0]        fw_high,  // write rights per hw register
  input  wire logic [15:0]        seg_rd,   // fetch segment read rights
  input  wire logic [15:0]        seg_wr,   // fetch segment write rights
  output logic                    ok,       // access allowed
  output logic                    local_sel // register held inside guard
);
  import sag_pkg::*;

  wire sag_grp_t  grp    = sag_grp_t'(addr[8:`SAG_GRP_LSB]);
  wire [3:0]      idx    = addr[5:`SAG_IDX_LSB];
  wire            is_bt  = (mode == SAG_BOOT) || (mode == SAG_TEST);
  wire            is_sys = (mode == SAG_SYS);
  wire            is_ctl = (mode == SAG_CTLS);
  wire            is_usr = (mode == SAG_USER);
  wire            pswu   = (addr == `SAG_PSW_UPPER);
  wire            xchg   = (addr == `SAG_XCHG_BASE) || (addr == `SAG_XCHG_SIZE);
  wire            fwreg  = (addr == `SAG_FW_LOW) || (addr == `SAG_FW_HIGH);
  wire            key1   = (addr == `SAG_KEY_FIRST);
  wire            key    = key1 || (addr == `SAG_KEY_SECOND);
  wire            ptr    = (addr == `SAG_PPTR_ZERO) || (addr == `SAG_PPTR_ONE);

  wire mapped = (addr[1:0] == 2'h0) &&
                ((grp == G_GEN) || (grp == G_SYS) || (grp == G_CTLS) ||
                 (grp == G_SEG && addr == `SAG_SEG_BASE) ||
                 (grp == G_FW && fwreg) ||
                 (grp == G_STAT && addr == `SAG_GSTAT) ||
                 (grp == G_HW && 32'(idx) < HW_REGS));

  // mode only, firewall words and segment rights feed the decision
  wire ctl_hw  = (wr ? fw_high[idx] : fw_low[idx]) ||
                 (addr == `SAG_CLK_SEL && !wr);
  wire ctl_ok  = (grp == G_FW && !wr) || (grp == G_CTLS) ||
                 (grp == G_HW && ctl_hw) || (pswu && !wr);
  wire sys_ok  = (grp == G_SEG) || (grp == G_SYS) || (grp == G_FW) ||
                 (grp == G_HW);
  wire usr_ok  = (grp == G_HW && (wr ? seg_wr[idx] : seg_rd[idx])) ||
                 (pswu && !wr);
  wire base_ok = (grp == G_GEN) || (grp == G_STAT) || is_bt ||
                 (is_sys && sys_ok) || (is_ctl && ctl_ok) || (is_usr && usr_ok);

  // explicit denials override every grant above
  wire deny = (grp == G_SEG && !is_sys) ||
              (xchg && !is_sys) ||
              (ptr && !wr) ||
              (addr == `SAG_RNG && wr) ||
              (key && !wr) ||
              (key1 && KEY1_LOCK);

  assign ok        = mapped && base_ok && !deny;
  assign local_sel = (grp == G_SEG) || (grp == G_FW) || (grp == G_STAT) || xchg;
endmodule // sag_decide

// >>> test/sag_group_model.sv
// register groups that sit behind the guard's forwarding port
`timescale 1ns/10ps
module sag_group_model (
  input  wire logic        pclk,      // bus clock
  input  wire logic        grp_sel,   // group selected
  input  wire logic        grp_we,    // write strobe
  input  wire logic [8:0]  grp_addr,  // byte address
  input  wire logic [31:0] grp_wdata, // write data
  output logic      [31:0] grp_rdata  // read data
);
  logic [31:0] mem_r [0:127];
  logic [31:0] last_r;
  initial begin
    last_r = 32'h0000_0000;
    for (int i = 0; i < 128; i++) mem_r[i] = 32'h5A00_0000 | 32'(i * 4);
  end
  always @(posedge pclk) begin
    if (grp_sel && grp_we) mem_r[grp_addr[8:2]] <= grp_wdata;
    last_r <= grp_rdata;
  end
  // deselected bus flips rather than holding its last word
  assign grp_rdata = grp_sel ? mem_r[grp_addr[8:2]] : ~last_r;
endmodule // sag_group_model

// >>> test/sag_guard_test.sv
// self-checking bench for the mode access guard
`timescale 1ns/10ps
`include "sag_params.svh"
module sag_guard_test;
  import sag_pkg::*;
  typedef struct packed {logic err; logic [31:0] data;} sag_note_t;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic        viol_pulse, grp_sel, grp_we, viol_due, lk_pslverr;
  logic [8:0]  paddr, grp_addr;
  logic [31:0] pwdata, prdata, grp_wdata, grp_rdata, gstat_exp;
  logic [15:0] seg_hw_rd, seg_hw_wr, seg_table_base, xchg_base, xchg_size;
  sag_mode_t   cpu_mode;
  sag_note_t   notes [$];
  logic [31:0] shadow [0:127];
  int          failures, tests_run;
  logic [8:0]  addr_tab [20] = '{9'h000, 9'h03C, 9'h040, 9'h048, 9'h080, 9'h084, 9'h088,
    9'h090, 9'h094, 9'h0C0, 9'h0C4, 9'h100, 9'h13C, 9'h140, 9'h144, 9'h148, 9'h14C,
    9'h17C, 9'h180, 9'h1C0};

  sag_guard #(.HW_REGS(16), .KEY1_LOCK(1'b0)) DUT (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_mode, .seg_hw_rd, .seg_hw_wr,
    .grp_sel, .grp_we, .grp_addr, .grp_wdata, .grp_rdata, .seg_table_base, .xchg_base,
    .xchg_size, .viol_pulse);
  sag_group_model partner (.pclk, .grp_sel, .grp_we, .grp_addr, .grp_wdata, .grp_rdata);
  // same traffic into a copy built with the first key locked
  sag_guard #(.HW_REGS(16), .KEY1_LOCK(1'b1)) DUT_LOCK (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata(), .pready(), .pslverr(lk_pslverr), .cpu_mode,
    .seg_hw_rd, .seg_hw_wr, .grp_sel(), .grp_we(), .grp_addr(), .grp_wdata(), .grp_rdata,
    .seg_table_base(), .xchg_base(), .xchg_size(), .viol_pulse());

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic is_local(logic [8:0] a);
    return a == `SAG_SEG_BASE || a == `SAG_XCHG_BASE || a == `SAG_XCHG_SIZE
      || a == `SAG_FW_LOW || a == `SAG_FW_HIGH;
  endfunction
  function automatic logic exp_ok(sag_mode_t m, logic [8:0] a, logic w,
                                  logic [15:0] srd, logic [15:0] swr);
    logic       full, wide;
    logic [3:0] i;
    full = (m == SAG_BOOT) || (m == SAG_TEST);
    wide = full || (m == SAG_SYS);
    i = a[5:2];
    case (a[8:6])
      3'h0: return 1'b1;
      3'h1: return (a == `SAG_SEG_BASE) && (m == SAG_SYS);
      3'h2: begin
        if (a == `SAG_XCHG_BASE || a == `SAG_XCHG_SIZE) return m == SAG_SYS;
        if (!w && a != `SAG_PSW_UPPER) return 1'b0;
        return wide || (!w && (m == SAG_CTLS || m == SAG_USER));
      end
      3'h3: return wide || (m == SAG_CTLS && !w);
      3'h4: return full || m == SAG_CTLS;
      3'h5: begin
        if (w ? a == `SAG_RNG : (a == `SAG_KEY_FIRST || a == `SAG_KEY_SECOND)) return 1'b0;
        if (wide) return 1'b1;
        if (m == SAG_CTLS) return (!w && i == 0) || (w ? shadow[49][i] : shadow[48][i]);
        return (m == SAG_USER) && (w ? swr[i] : srd[i]);
      end
      3'h6: return a == `SAG_GSTAT;
      default: return 1'b0;
    endcase
  endfunction
  task automatic check1(string what, logic exp, logic seen);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %0b seen %0b", what, exp, seen);
    end
  endtask
  task automatic check32(string what, logic [31:0] exp, logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // one apb transfer; leaves psel high so a setup may follow at once
  task automatic access(sag_mode_t m, logic [8:0] a, logic w, logic [31:0] d);
    logic        ok;
    logic [15:0] srd, swr;
    logic [31:0] rd;
    srd = 16'($urandom);
    swr = 16'($urandom);
    ok = exp_ok(m, a, w, srd, swr);
    rd = 32'h0000_0000;
    if (ok && !w) rd = (a == `SAG_GSTAT) ? gstat_exp : shadow[a[8:2]];
    if (ok && w && a != `SAG_GSTAT) shadow[a[8:2]] = is_local(a) ? {16'h0000, d[15:0]} : d;
    if (ok && w && a == `SAG_GSTAT && d[0]) gstat_exp[0] = 1'b0;
    if (!ok) gstat_exp = {7'h00, a, 15'h0000, 1'b1};
    notes.push_back({~ok, rd});
    cpu_mode <= m;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    seg_hw_rd <= srd;
    seg_hw_wr <= swr;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    ce <= ($urandom % 4) != 0;
    for (int n = 0; n < 20; n++) begin
      @(posedge pclk);
      ce <= (pready === 1'b1) || (($urandom % 4) != 0);
      if (pready === 1'b1) break;
    end
    check1("pready", 1'b1, pready);
  endtask
  always @(posedge pclk) begin
    sag_note_t n;
    if (presetn) begin
      check1("violation pulse", viol_due, viol_pulse);
      viol_due = 1'b0;
      if (psel && penable && pready === 1'b1 && notes.size() != 0) begin
        n = notes.pop_front();
        check1("slave error", n.err, pslverr);
        check32("read data", n.data, prdata);
        check1("locked key error", n.err || paddr == `SAG_KEY_FIRST, lk_pslverr);
        viol_due = n.err;
      end
    end
  end
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ample margin over some 700 transfers of a few cycles each
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, seg_hw_rd, seg_hw_wr} = '0;
    cpu_mode = SAG_BOOT;
    {failures, tests_run, gstat_exp, viol_due} = '0;
    for (int i = 0; i < 128; i++) shadow[i] = is_local(9'(i * 4)) ? 32'h0 : 32'h5A00_0000 | (i * 4);
    void'($urandom(4922));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check32("segment base", 32'h0, {16'h0000, seg_table_base});
    access(SAG_USER, `SAG_SEG_BASE, 1'b1, 32'h0000_1234);
    access(SAG_SYS, `SAG_SEG_BASE, 1'b0, 32'h0);
    access(SAG_USER, `SAG_GSTAT, 1'b0, 32'h0);
    access(SAG_USER, `SAG_GSTAT, 1'b1, 32'h0000_0001);
    access(SAG_USER, `SAG_GSTAT, 1'b0, 32'h0);
    $display("reset and status test done");
    repeat (700) begin
      logic [8:0] a;
      a = addr_tab[$urandom % 20];
      access(sag_mode_t'($urandom % 5), a, ($urandom % 2) && a != `SAG_GSTAT, $urandom);
      if ($urandom % 4 == 0) begin
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge pclk);
    $display("random mode test done");
    check32("segment base", shadow[16], {16'h0000, seg_table_base});
    check32("exchange base", shadow[36], {16'h0000, xchg_base});
    check32("exchange size", shadow[37], {16'h0000, xchg_size});
    $display("register port test done");
    complete_run();
  end
endmodule // sag_guard_test
